// ---- ldp_defines.svh ----
// constants of the link controller dma port: offsets, fields, counts
`ifndef LDP_DEFINES_SVH
`define LDP_DEFINES_SVH
// apb register byte offsets
`define LDP_OFF_CTRL      12'h000
`define LDP_OFF_TBASE     12'h004
`define LDP_OFF_STATUS    12'h008
`define LDP_OFF_RSA       12'h00c
// control fields
`define LDP_CTRL_MODE_LO  0
`define LDP_CTRL_MODE_HI  1
`define LDP_CTRL_ENABLE   2
`define LDP_CTRL_HALT_CLR 3
// reset values
`define LDP_RST_CTRL      4'h0
`define LDP_RST_TBASE     16'h0000
// descriptor layout: byte 1 is offset 0
`define LDP_RDY_BIT       0
`define LDP_CMP_VAL       8'h80
`define LDP_TABLE_BYTES   16'h0040
// sys_clock_out half period in pclk cycles (400 ns period at 50 MHz)
`define LDP_CKO_HALF      5'd10
// timing in sys_clock_out periods, tenure in good bus cycles
`define LDP_MAX_TENURE    3'd5
`define LDP_DESC_EXTRA    2'd2
`define LDP_MR_MIN_LOW    5'd6
`define LDP_MR_MIN_HIGH   5'd6
`define LDP_MR_WINDOW     5'd30
// host register cycle length in pclk cycles
`define LDP_CPU_ACC_CYC   3'd4
`endif

// ---- ldp_pkg.sv ----
// types of the link controller dma port
package ldp_pkg;
  typedef enum logic [2:0] {
    LDP_IDLE = 3'b000,
    LDP_REQ  = 3'b001,
    LDP_ADDR = 3'b010,
    LDP_STRB = 3'b011,
    LDP_PAR  = 3'b100,
    LDP_REL  = 3'b101
  } ldp_state_t;
  typedef enum logic [1:0] {
    LDP_NORMAL = 2'b00,
    LDP_NEAR   = 2'b01,
    LDP_FAR    = 2'b10,
    LDP_ECHO   = 2'b11
  } ldp_mode_t;
endpackage

// ---- ldp_reset_style.sv ----
// master reset pulse qualifier and bus style selector
`timescale 1ns/1ps
`include "ldp_defines.svh"
module ldp_reset_style (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic mr_lvl,
  input  wire logic cko_rise,
  output logic      split_style
);
  logic [4:0] low_cnt_r;
  logic [4:0] high_cnt_r;
  logic       armed_r;
  logic       mr_d_r;

  // count clock-output periods in each level of the reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r  <= 5'h00;
      high_cnt_r <= 5'h00;
      mr_d_r     <= 1'b1;
    end else begin
      mr_d_r <= mr_lvl;
      if (mr_lvl != mr_d_r) begin
        low_cnt_r  <= 5'h00;
        high_cnt_r <= 5'h00;
      end else if (cko_rise) begin
        if (!mr_lvl && low_cnt_r != 5'h1f)
          low_cnt_r <= low_cnt_r + 5'h01;
        if (mr_lvl && high_cnt_r != 5'h1f)
          high_cnt_r <= high_cnt_r + 5'h01;
      end
    end
  end

  // one valid pulse gives data strobe, a second in the window gives split
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r     <= 1'b0;
      split_style <= 1'b0;
    end else if (mr_lvl && !mr_d_r && low_cnt_r >= `LDP_MR_MIN_LOW) begin
      if (armed_r) begin
        split_style <= 1'b1;
        armed_r     <= 1'b0;
      end else begin
        split_style <= 1'b0;
        armed_r     <= 1'b1;
      end
    end else if (!mr_lvl && mr_d_r && armed_r && high_cnt_r < `LDP_MR_MIN_HIGH) begin
      // gap judged at the falling edge, before the counters restart
      armed_r <= 1'b0; // too short a gap starts over
    end else if (mr_lvl && armed_r && high_cnt_r >= `LDP_MR_WINDOW) begin
      armed_r <= 1'b0; // window over, next pulse is a new sequence
    end
  end
endmodule

// ---- ldp_dma_port.sv ----
// link controller dma port: descriptor completion bus master with apb control
`timescale 1ns/1ps
`include "ldp_defines.svh"
module ldp_dma_port (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_done,
  input  wire logic        frame_err,
  input  wire logic [15:0] frame_len,
  output logic             packet_received_interrupt,
  output logic             parity_error_interrupt,
  input  wire logic        master_reset_n,
  output logic             sys_clock_out,
  output logic             bus_request_n,
  input  wire logic        bus_grant_n,
  input  wire logic        chain_request_in_n,
  output logic             chain_grant_out_n,
  input  wire logic        mem_ready_n,
  input  wire logic        parity_valid_n,
  output logic [15:0]      mem_addr,
  output logic             mem_rw_n,
  output logic             address_strobe_n,
  output logic             shared_strobe_n,
  output logic             write_strobe_n,
  output logic             bus_oe_n,
  input  wire logic [7:0]  mem_data_in,
  output logic [7:0]       mem_data_out,
  output logic             mem_data_oe_n,
  input  wire logic        cpu_cs_n,
  output logic             cpu_ready_n,
  output logic             cpu_ready_oe_n,
  input  wire logic        ser_tx_core,
  output logic             ser_rx_core,
  output logic             swap_addresses,
  input  wire logic        ser_rx_pin,
  output logic             ser_tx_pin
);
  localparam int NPIN = 6;
  ldp_pkg::ldp_state_t state_r;
  ldp_pkg::ldp_mode_t  mode;
  logic [NPIN-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic        grant_s, ready_s, parity_valid_n_s, chain_s, mr_s, cs_s;
  logic [4:0]  half_cnt_r;
  logic        cko_rise, cko_fall;
  logic [3:0]  ctrl_r;
  logic [15:0] tbase_r;
  logic [15:0] rsa_r;
  logic [15:0] len_r;
  logic [2:0]  idx_r;
  logic [2:0]  step_r;
  logic [2:0]  tenure_r;
  logic [1:0]  extra_r;
  logic        retry_r;
  logic        halted_r;
  logic        nobuf_r;
  logic        split_style;
  logic        own_req;
  logic        wr_now;
  logic [2:0]  cpu_cnt_r;
  logic        apb_wr;
  logic        apb_rd;
  logic        hit;

  // step table: byte offset inside the element (byte 1 is offset 0)
  function automatic logic [2:0] step_off(input logic [2:0] s);
    case (s)
      3'h1:    step_off = 3'h3;
      3'h2:    step_off = 3'h4;
      3'h3:    step_off = 3'h1;
      3'h4:    step_off = 3'h2;
      default: step_off = 3'h0;
    endcase
  endfunction

  // steps 0..2 read the element, steps 3..5 write it back
  function automatic logic step_wr(input logic [2:0] s);
    step_wr = (s >= 3'h3);
  endfunction

  assign grant_s = lvl_r[0];
  assign ready_s = lvl_r[1];
  assign parity_valid_n_s  = lvl_r[2];
  assign chain_s = lvl_r[3];
  assign mr_s    = lvl_r[4];
  assign cs_s    = lvl_r[5];

  // pin inputs: three stages, a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r[g]  <= 1'b1;
          s2_r[g]  <= 1'b1;
          s3_r[g]  <= 1'b1;
          lvl_r[g] <= 1'b1;
        end else begin
          s1_r[g] <= (g == 0) ? bus_grant_n :
                     (g == 1) ? mem_ready_n :
                     (g == 2) ? parity_valid_n :
                     (g == 3) ? chain_request_in_n :
                     (g == 4) ? master_reset_n : cpu_cs_n;
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g])
            lvl_r[g] <= s3_r[g];
        end
      end
    end
  endgenerate

  // clock output divider; events mark the pclk edge where it toggles
  assign cko_rise = (half_cnt_r == `LDP_CKO_HALF - 5'd1) && !sys_clock_out;
  assign cko_fall = (half_cnt_r == `LDP_CKO_HALF - 5'd1) && sys_clock_out;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_r    <= 5'h00;
      sys_clock_out <= 1'b0;
    end else if (half_cnt_r == `LDP_CKO_HALF - 5'd1) begin
      half_cnt_r    <= 5'h00;
      sys_clock_out <= ~sys_clock_out;
    end else begin
      half_cnt_r <= half_cnt_r + 5'h01;
    end
  end

  ldp_reset_style u_style (
    .pclk        (pclk),
    .presetn     (presetn),
    .mr_lvl      (mr_s),
    .cko_rise    (cko_rise),
    .split_style (split_style)
  );

  // apb slave: zero wait states, unmapped offsets answer with an error
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign hit     = (paddr == `LDP_OFF_CTRL) || (paddr == `LDP_OFF_TBASE) ||
                   (paddr == `LDP_OFF_STATUS) || (paddr == `LDP_OFF_RSA);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `LDP_RST_CTRL;
      tbase_r <= `LDP_RST_TBASE;
    end else begin
      ctrl_r[`LDP_CTRL_HALT_CLR] <= 1'b0; // self-clearing command bit
      if (apb_wr && paddr == `LDP_OFF_CTRL)
        ctrl_r <= pwdata[3:0];
      if (apb_wr && paddr == `LDP_OFF_TBASE)
        tbase_r <= pwdata[15:0];
    end
  end

  // read data registered at the setup edge, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `LDP_OFF_CTRL:   prdata <= {28'h0, ctrl_r};
        `LDP_OFF_TBASE:  prdata <= {16'h0, tbase_r};
        `LDP_OFF_STATUS: prdata <= {23'h0, retry_r, split_style, nobuf_r, halted_r,
                                    (state_r != ldp_pkg::LDP_IDLE), 1'b0, idx_r};
        `LDP_OFF_RSA:    prdata <= {16'h0, rsa_r};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // bus request and daisy chain: merge requests, pass grant when not ours
  assign own_req = (state_r != ldp_pkg::LDP_IDLE) && (state_r != ldp_pkg::LDP_REL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_request_n     <= 1'b1;
      chain_grant_out_n <= 1'b1;
    end else begin
      bus_request_n     <= !(own_req || !chain_s);
      chain_grant_out_n <= grant_s || own_req;
    end
  end

  // master state machine, stepped on clock-output edges once a frame starts it from idle
  assign wr_now = step_wr(step_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= ldp_pkg::LDP_IDLE;
      step_r    <= 3'h0;
      tenure_r  <= 3'h0;
      extra_r   <= 2'h0;
      retry_r   <= 1'b0;
      halted_r  <= 1'b0;
      nobuf_r   <= 1'b0;
      idx_r     <= 3'h0;
      len_r     <= 16'h0000;
      rsa_r     <= 16'h0000;
      packet_received_interrupt <= 1'b0;
      parity_error_interrupt    <= 1'b0;
    end else begin
      packet_received_interrupt <= 1'b0;
      parity_error_interrupt    <= 1'b0;
      if (ctrl_r[`LDP_CTRL_HALT_CLR]) begin
        halted_r <= 1'b0;
        nobuf_r  <= 1'b0;
      end
      if (!mr_s) begin
        state_r <= ldp_pkg::LDP_IDLE;
      end else begin
        unique case (state_r)
          ldp_pkg::LDP_IDLE: begin
            // a frame with an error never reaches the element
            if (frame_done && !frame_err && ctrl_r[`LDP_CTRL_ENABLE] && !halted_r) begin
              len_r    <= frame_len;
              step_r   <= 3'h0;
              retry_r  <= 1'b0;
              tenure_r <= 3'h0;
              state_r  <= ldp_pkg::LDP_REQ;
            end
          end
          ldp_pkg::LDP_REQ: begin
            if (cko_fall && !grant_s) begin
              tenure_r <= 3'h0;
              state_r  <= ldp_pkg::LDP_ADDR;
            end
          end
          ldp_pkg::LDP_ADDR: begin
            if (cko_fall) begin
              extra_r <= wr_now ? 2'h0 : `LDP_DESC_EXTRA;
              state_r <= ldp_pkg::LDP_STRB;
            end
          end
          ldp_pkg::LDP_STRB: begin
            if (cko_rise) begin
              if (extra_r != 2'h0)
                extra_r <= extra_r - 2'h1;
              else if (!ready_s)
                state_r <= ldp_pkg::LDP_PAR;
            end
          end
          ldp_pkg::LDP_PAR: begin
            if (cko_fall) begin
              if (parity_valid_n_s) begin
                if (!retry_r) begin
                  retry_r <= 1'b1;
                  state_r <= ldp_pkg::LDP_ADDR;
                end else begin
                  halted_r <= 1'b1;
                  parity_error_interrupt <= 1'b1;
                  state_r  <= ldp_pkg::LDP_IDLE;
                end
              end else begin
                retry_r  <= 1'b0;
                tenure_r <= tenure_r + 3'h1;
                step_r   <= step_r + 3'h1;
                if (step_r == 3'h1)
                  rsa_r[7:0] <= mem_data_in;
                if (step_r == 3'h2)
                  rsa_r[15:8] <= mem_data_in;
                if (step_r == 3'h0 && !mem_data_in[`LDP_RDY_BIT]) begin
                  nobuf_r <= 1'b1; // no buffer offered, element left alone
                  state_r <= ldp_pkg::LDP_IDLE;
                end else if (step_r == 3'h5) begin
                  idx_r   <= idx_r + 3'h1; // circular queue of eight
                  packet_received_interrupt <= 1'b1;
                  state_r <= ldp_pkg::LDP_IDLE;
                end else if (tenure_r + 3'h1 == `LDP_MAX_TENURE) begin
                  state_r <= ldp_pkg::LDP_REL;
                end else begin
                  state_r <= ldp_pkg::LDP_ADDR;
                end
              end
            end
          end
          ldp_pkg::LDP_REL: begin
            if (cko_fall)
              state_r <= ldp_pkg::LDP_REQ; // give the bus up for one period
          end
        endcase
      end
    end
  end

  // pin drive: direction and address set in the address phase, strobes after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr         <= 16'h0000;
      mem_rw_n         <= 1'b1;
      address_strobe_n <= 1'b1;
      shared_strobe_n  <= 1'b1;
      write_strobe_n   <= 1'b1;
      mem_data_out     <= 8'h00;
    end else begin
      // element sits after the eight transmit elements
      mem_addr <= tbase_r + `LDP_TABLE_BYTES + {10'h0, idx_r, 3'h0} + {13'h0, step_off(step_r)};
      mem_rw_n <= !wr_now; // settled one period before the strobe
      case (step_r)
        3'h3:    mem_data_out <= len_r[7:0]; // count low byte first
        3'h4:    mem_data_out <= len_r[15:8];
        default: mem_data_out <= `LDP_CMP_VAL; // complete set, ready cleared
      endcase
      address_strobe_n <= !(state_r == ldp_pkg::LDP_STRB || state_r == ldp_pkg::LDP_PAR);
      // one pin: read enable in split style, data strobe otherwise
      shared_strobe_n <= !((state_r == ldp_pkg::LDP_STRB || state_r == ldp_pkg::LDP_PAR) &&
                           (!split_style || !wr_now));
      write_strobe_n  <= !((state_r == ldp_pkg::LDP_STRB || state_r == ldp_pkg::LDP_PAR) &&
                           split_style && wr_now);
    end
  end

  // float the bus outputs while master reset is low, drive them only while granted
  assign bus_oe_n      = !(mr_s && own_req && state_r != ldp_pkg::LDP_REQ);
  assign mem_data_oe_n = !(mr_s && own_req && state_r != ldp_pkg::LDP_REQ && wr_now);

  // host register cycle: ends at once when chip select goes high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_cnt_r   <= 3'h0;
      cpu_ready_n <= 1'b1;
    end else if (cs_s) begin
      cpu_cnt_r   <= 3'h0;
      cpu_ready_n <= 1'b1;
    end else if (cpu_cnt_r != `LDP_CPU_ACC_CYC) begin
      cpu_cnt_r <= cpu_cnt_r + 3'h1;
    end else begin
      cpu_ready_n <= 1'b0;
    end
  end
  assign cpu_ready_oe_n = !(mr_s && !cs_s);

  // test modes: serial path registered so the pins see clean levels
  assign mode = ldp_pkg::ldp_mode_t'(ctrl_r[`LDP_CTRL_MODE_HI:`LDP_CTRL_MODE_LO]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_rx_core    <= 1'b1;
      ser_tx_pin     <= 1'b1;
      swap_addresses <= 1'b0;
    end else begin
      ser_rx_core    <= (mode == ldp_pkg::LDP_NEAR) ? ser_tx_core : ser_rx_pin;
      ser_tx_pin     <= (mode == ldp_pkg::LDP_ECHO) ? ser_rx_pin :
                        (mode == ldp_pkg::LDP_NEAR) ? 1'b1 : ser_tx_core;
      swap_addresses <= (mode == ldp_pkg::LDP_NEAR) || (mode == ldp_pkg::LDP_FAR);
    end
  end

  // checks on the master
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_GRANT_ON_FALL: assert property ($rose(state_r == ldp_pkg::LDP_ADDR) && $past(state_r) == ldp_pkg::LDP_REQ
                     |-> $past(cko_fall) && !$past(grant_s)) else $error("grant taken off a fall");
  AST_READY_ON_RISE: assert property (state_r == ldp_pkg::LDP_STRB ##1 state_r == ldp_pkg::LDP_PAR
                     |-> $past(cko_rise) && !$past(ready_s)) else $error("ready not seen low");
  AST_TENURE_MAX: assert property (tenure_r <= `LDP_MAX_TENURE) else $error("tenure too long");
  AST_DIR_BEFORE_AS: assert property ($fell(address_strobe_n) |-> $stable(mem_rw_n)) else $error("rw moved at strobe");
  AST_FLOAT_IN_RESET: assert property (!mr_s |-> bus_oe_n && mem_data_oe_n && cpu_ready_oe_n)
                      else $error("driving in reset");
  AST_PARITY_HALT: assert property (state_r == ldp_pkg::LDP_PAR && cko_fall && parity_valid_n_s && retry_r && mr_s
                   |=> halted_r && parity_error_interrupt) else $error("second parity fail not halted");
  AST_NO_RSA_WRITE: assert property (!mem_rw_n && !address_strobe_n |-> mem_addr[2:0] <= 3'h2)
                    else $error("start address written");
  AST_PKT_IRQ: assert property (packet_received_interrupt |-> idx_r == $past(idx_r) + 3'h1 && state_r == ldp_pkg::LDP_IDLE)
               else $error("irq without completion");
  AST_CHAIN_GRANT: assert property (own_req |=> chain_grant_out_n) else $error("grant passed while owned");
  AST_CS_ENDS: assert property (cs_s |=> cpu_ready_n && cpu_cnt_r == 3'h0) else $error("cycle not ended");
endmodule

// ---- ldp_mem_model.sv ----
// partner: bus arbiter and byte-wide system memory
`timescale 1ns/1ps
module ldp_mem_model (
  input  wire logic        pclk,
  input  wire logic        bus_request_n,
  output logic             bus_grant_n,
  input  wire logic        bus_oe_n,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rw_n,
  input  wire logic        address_strobe_n,
  input  wire logic        shared_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [7:0]  mem_data_out,
  output logic [7:0]       mem_data_in,
  output logic             mem_ready_n,
  output logic             parity_valid_n
);
  logic [7:0] mem [0:65535];
  int         fail_left = 0;
  int         wait_max = 2;
  int         tenure_err = 0;
  int         cnt = 0;
  int         lim = 0;
  int         cyc = 0;
  logic       act;
  logic       act_q = 1'b0;
  // a cycle is live while the port owns the bus with address and a strobe low
  assign act = !bus_oe_n && !address_strobe_n && !(shared_strobe_n && write_strobe_n);
  initial begin
    bus_grant_n = 1'b1;
    mem_ready_n = 1'b1;
    parity_valid_n = 1'b0;
    mem_data_in = 8'h00;
  end
  // grant after a random wait, withdrawn as soon as the request goes
  always @(posedge pclk) begin
    if (bus_request_n !== 1'b0) bus_grant_n <= 1'b1;
    else if ($urandom_range(3) == 0) bus_grant_n <= 1'b0;
  end
  // ready after a bounded stretch far below the write limit; parity rides with ready
  always @(posedge pclk) begin
    act_q <= act;
    if (act) begin
      if (!act_q) lim = $urandom_range(wait_max);
      cnt = act_q ? cnt + 1 : 0;
      if (cnt >= lim) mem_ready_n <= 1'b0;
      if (cnt >= lim) parity_valid_n <= (fail_left != 0);
      if (!mem_rw_n && !mem_ready_n) mem[mem_addr] <= mem_data_out;
    end else begin
      mem_ready_n <= 1'b1;
      parity_valid_n <= 1'b0;
      if (act_q && parity_valid_n) fail_left--; // each failed attempt uses one
      if (act_q && !parity_valid_n) cyc++;
    end
    // good cycles within one grant, never more than five
    if (bus_grant_n) cyc = 0;
    if (cyc > 5) tenure_err++;
  end
  // read data only during a live read, a changing pattern otherwise so stale bytes never pass
  always @(posedge pclk) mem_data_in <= (act && mem_rw_n) ? mem[mem_addr] : ~mem_data_in;
endmodule

// ---- link_controller_dma_port_test.sv ----
// self-checking bench of the dma port against its bus partner
`timescale 1ns/1ps
`include "ldp_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
`define WAITFOR(c, n) begin cmp_count++; for (wn = 0; wn < n && !(c); wn++) @(posedge pclk); \
  if (wn >= n) begin miscompares++; finish_test(); end end
module link_controller_dma_port_test;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic        frame_done = 1'b0, frame_err = 1'b0, master_reset_n = 1'b1, chain_request_in_n = 1'b1;
  logic        cpu_cs_n = 1'b1, ser_tx_core = 1'b0, ser_rx_pin = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] frame_len = 16'h0, mem_addr, tbase;
  logic [7:0]  mem_data_in, mem_data_out;
  logic        pready, pslverr, packet_received_interrupt, parity_error_interrupt, sys_clock_out, bus_request_n;
  logic        bus_grant_n, chain_grant_out_n, mem_ready_n, parity_valid_n, mem_rw_n, address_strobe_n;
  logic        shared_strobe_n, write_strobe_n, bus_oe_n, mem_data_oe_n, cpu_ready_n, cpu_ready_oe_n;
  logic        ser_rx_core, swap_addresses, ser_tx_pin;
  int          miscompares = 0, cmp_count = 0, wn, idx = 0, irq_n = 0, par_n = 0;
  ldp_dma_port dut_u (.*);
  ldp_mem_model mem_u (.*);
  always #10 pclk = ~pclk;
  // interrupts are one-cycle pulses, so count them as they pass
  always @(posedge pclk) begin
    if (packet_received_interrupt === 1'b1) irq_n++;
    if (parity_error_interrupt === 1'b1) par_n++;
  end
  task automatic finish_test();
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    `WAITFOR(pready === 1'b1, 20)
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle edge so a following call never re-drives psel in this step
  endtask
  // master reset pulse of eight clock-output periods, then a high gap
  task automatic pulse(input int gap);
    master_reset_n <= 1'b0;
    repeat (160) @(posedge pclk);
    master_reset_n <= 1'b1;
    repeat (gap) @(posedge pclk);
  endtask
  // one received frame against the element at the expected index
  task automatic frame(input int fails, input logic err, input int wmax);
    logic [15:0] len, rsa, ea;
    int          n0;
    len = 16'($urandom);
    rsa = 16'($urandom);
    ea = tbase + 16'h0040 + 16'(idx * 8);
    n0 = irq_n;
    mem_u.mem[ea + 1] = 8'h00;
    mem_u.mem[ea + 3] = rsa[7:0];
    mem_u.mem[ea + 4] = rsa[15:8];
    mem_u.mem[ea] = 8'h01; // start address first, ready flag last
    mem_u.fail_left = fails;
    mem_u.wait_max = wmax;
    frame_done <= 1'b1;
    frame_err <= err;
    frame_len <= len;
    @(posedge pclk);
    frame_done <= 1'b0;
    frame_err <= 1'b0;
    if (err) begin
      repeat (3000) @(posedge pclk);
      `CHK(irq_n, n0)
      `CHK(mem_u.mem[ea + 1], 8'h00)
    end else begin
      `WAITFOR(packet_received_interrupt === 1'b1 || parity_error_interrupt === 1'b1, 20000)
      repeat (60) @(posedge pclk);
      apb(1'b0, `LDP_OFF_STATUS, 32'h0);
      if (fails > 1) begin
        `CHK(par_n, 1)
        `CHK(rd[5], 1'b1)
        apb(1'b1, `LDP_OFF_CTRL, 32'hc);
        apb(1'b0, `LDP_OFF_STATUS, 32'h0);
        `CHK(rd[5], 1'b0)
      end else begin
        idx = (idx + 1) % 8;
        `CHK(irq_n, n0 + 1)
        `CHK(rd[2:0], idx[2:0])
        `CHK(rd[5], 1'b0)
        `CHK(mem_u.mem[ea], `LDP_CMP_VAL)
        `CHK({mem_u.mem[ea + 2], mem_u.mem[ea + 1]}, len)
        `CHK({mem_u.mem[ea + 4], mem_u.mem[ea + 3]}, rsa)
        `CHK(mem_u.tenure_err, 0)
        apb(1'b0, `LDP_OFF_RSA, 32'h0);
        `CHK(rd[15:0], rsa)
      end
    end
  endtask
  initial begin
    void'($urandom(32'hdea88d9e));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (820) @(posedge pclk);
    // outputs float under master reset even with requests pending
    cpu_cs_n <= 1'b0;
    chain_request_in_n <= 1'b0;
    master_reset_n <= 1'b0;
    repeat (100) @(posedge pclk);
    `CHK(bus_oe_n, 1'b1)
    `CHK(mem_data_oe_n, 1'b1)
    `CHK(cpu_ready_oe_n, 1'b1)
    repeat (60) @(posedge pclk);
    master_reset_n <= 1'b1;
    cpu_cs_n <= 1'b1;
    chain_request_in_n <= 1'b1;
    repeat (200) @(posedge pclk);
    pulse(700);
    apb(1'b0, `LDP_OFF_STATUS, 32'h0);
    `CHK(rd[7], 1'b1)
    pulse(700);
    apb(1'b0, `LDP_OFF_STATUS, 32'h0);
    `CHK(rd[7], 1'b0)
    apb(1'b0, `LDP_OFF_CTRL, 32'h0);
    `CHK(rd[3:0], `LDP_RST_CTRL)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(er, 1'b1)
    tbase = 16'($urandom) & 16'h7ff8;
    apb(1'b1, `LDP_OFF_TBASE, {16'h0, tbase});
    apb(1'b0, `LDP_OFF_TBASE, 32'h0);
    `CHK(rd[15:0], tbase)
    // every test mode with transmit and receive held opposite
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `LDP_OFF_CTRL, 32'(k));
      ser_tx_core <= k[0];
      ser_rx_pin <= !k[0];
      repeat (6) @(posedge pclk);
      `CHK(swap_addresses, k == 1 || k == 2)
      if (k != 3) `CHK(ser_rx_core, (k == 1) ? ser_tx_core : ser_rx_pin)
      if (k != 1) `CHK(ser_tx_pin, (k == 3) ? ser_rx_pin : ser_tx_core)
    end
    apb(1'b1, `LDP_OFF_CTRL, 32'h4);
    chain_request_in_n <= 1'b0;
    `WAITFOR(bus_request_n === 1'b0, 10)
    `WAITFOR(chain_grant_out_n === 1'b0, 80)
    chain_request_in_n <= 1'b1;
    `WAITFOR(bus_request_n === 1'b1 && chain_grant_out_n === 1'b1, 80)
    cpu_cs_n <= 1'b0;
    `WAITFOR(cpu_ready_n === 1'b0, 16)
    `CHK(cpu_ready_oe_n, 1'b0)
    cpu_cs_n <= 1'b1;
    `WAITFOR(cpu_ready_n === 1'b1, 8)
    frame(0, 1'b1, 2);
    frame(1, 1'b0, 40);
    // a close pair of pulses moves the remaining frames onto split enables
    pulse(200);
    pulse(700);
    apb(1'b0, `LDP_OFF_STATUS, 32'h0);
    `CHK(rd[7], 1'b1)
    for (int k = 0; k < 8; k++) frame(0, 1'b0, k * 5);
    frame(2, 1'b0, 2);
    finish_test();
  end
endmodule
